// *** ftt_bank.v ***
// Fan threshold register bank with its automatic fan loop, on AXI4-Lite.
//
// Notes on behaviour
// - Above start temperature, fan ramps from minimum duty
// - Any critical overrun forces all outputs full duty
// - Critical limit 0x80 disables that channel's forcing
// - Full duty holds until below limit minus hysteresis
// - Alert pin pulls low quarter degree past limit
// - Shared register: local low nibble, remote1 high
// - Remote2 hysteresis in high nibble only
// - Hysteresis fields span zero to fifteen degrees
// - Below start, hold minimum duty until hysteresis passes
// - Lock bit makes whole group read-only
// - Test-enable bit zero enters pin-chain test mode
// - Remote1 offset added to every remote1 reading
// - Config bit selects remote1 offset range, resolution
// - Minimum duty scales linearly, 0x00 off, 0xFF full
//
// Temperatures arrive as unsigned quarter degrees: bits [9:2] are whole
// degrees, bits [1:0] the fraction. Channel 0 is remote 1, channel 1 is
// local and channel 2 is remote 2; fan output n follows channel n.
//
// Register access over AXI4-Lite is this design's own decision.
`include "ftt_bank_regs.vh"

module ftt_bank #(
	parameter ADDR_W = 10
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [9:0] remote1_temp_raw,
	input wire [9:0] local_temp,
	input wire [9:0] remote2_temp,
	output reg [7:0] fan_duty_0,
	output reg [7:0] fan_duty_1,
	output reg [7:0] fan_duty_2,
	output wire pin_chain_test_on,
	output wire overtemp_signal_pin_o,
	output reg overtemp_signal_pin_oe
);

////////////////////////////////////////////////////////////////////////////////

reg [7:0] fan_start_temperature [0:2];
reg [7:0] critical_limit [0:2];
reg [7:0] minimum_fan_duty [0:2];
reg [2:0] fan_ramp_span [0:2];
reg [3:0] local_hyst_nibble;
reg [3:0] remote1_hyst_nibble;
reg [3:0] remote2_hyst_nibble;
reg test_on;
reg [7:0] remote1_temp_offset;
reg lock;
reg offset_coarse;
reg pin_out_en;
reg [2:0] crit_hold;
reg [2:0] fan_active;
reg [9:0] remote1_temp;

reg aw_held;
reg w_held;
reg [ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

localparam [7:0] RST_HYST_R1_LOC = `FTT_RST_HYST_R1_LOC;

wire [9:0] temp_q [0:2];
wire [3:0] hyst [0:2];

assign temp_q[0] = remote1_temp;
assign temp_q[1] = local_temp;
assign temp_q[2] = remote2_temp;
assign hyst[0] = remote1_hyst_nibble;
assign hyst[1] = local_hyst_nibble;
assign hyst[2] = remote2_hyst_nibble;

assign pin_chain_test_on = test_on;
// The alert pin is open drain: it only ever pulls low.
assign overtemp_signal_pin_o = 1'b0;

////////////////////////////////////////////////////////////////////////////////

// Limit minus hysteresis in degrees, clamped at zero.
function [7:0] sat_sub;
	input [7:0] limit;
	input [3:0] h;
	begin
		if (limit > {4'h0, h}) begin
			sat_sub = limit - {4'h0, h};
		end else begin
			sat_sub = 8'h00;
		end
	end
endfunction

// Degrees widened to quarter degrees, one degree per step.
function [9:0] to_q;
	input [7:0] deg;
	begin
		to_q = {deg, 2'b00};
	end
endfunction

// Ramp from the minimum duty up to full over 2^(code+1) degrees.
// Duty is an 8-bit fraction of full scale, 0x00 off.
function [7:0] ramp_duty;
	input [7:0] dmin;
	input [9:0] excess;
	input [2:0] code;
	reg [17:0] prod;
	reg [17:0] add;
	reg [17:0] sum;
	begin
		prod = {10'h000, 8'hFF - dmin} * {8'h00, excess};
		add = prod >> ({2'b00, code} + 5'd3);
		sum = add + {10'h000, dmin};
		if (sum > 18'h000FF) begin
			ramp_duty = `FTT_DUTY_FULL;
		end else begin
			ramp_duty = sum[7:0];
		end
	end
endfunction

function is_mapped;
	input [7:0] idx;
	begin
		is_mapped = (idx >= `FTT_IDX_GROUP_CTRL && idx <= `FTT_IDX_R1_CORR)
			|| (idx >= `FTT_IDX_MIN_DUTY_R1 && idx <= `FTT_IDX_R1_OFFSET);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Remote 1 correction. The offset is signed; the range bit picks half a
// degree per step (fine) or a whole degree (coarse). The result clamps
// at the ends of the measurement scale rather than wrapping.

wire [11:0] ofs_q = offset_coarse ?
	{{2{remote1_temp_offset[7]}}, remote1_temp_offset, 2'b00} :
	{{3{remote1_temp_offset[7]}}, remote1_temp_offset, 1'b0};
wire [11:0] r1_sum = {2'b00, remote1_temp_raw} + ofs_q;
reg [9:0] next_remote1_temp;

always @* begin
	if (remote1_temp_offset[7] && r1_sum[11]) begin
		next_remote1_temp = 10'h000;
	end else if (!remote1_temp_offset[7] && r1_sum[10]) begin
		next_remote1_temp = 10'h3FF;
	end else begin
		next_remote1_temp = r1_sum[9:0];
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		remote1_temp <= 10'h000;
	end else begin
		remote1_temp <= next_remote1_temp;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Fan loop and fail-safe. Forcing is decided on whole degrees above the
// limit; the alert pin reacts a quarter degree past the limit already.
// One degree past is written as more than three quarters past, so that a
// setting of 0xFF cannot wrap the 10-bit threshold round to zero.

reg [2:0] over_crit;
reg [2:0] below_crit_rel;
reg [2:0] alert_hit;
reg [2:0] above_start;
reg [2:0] below_start_rel;
reg [7:0] next_duty [0:2];
integer c;
integer fc;
integer rc;

always @* begin
	for (c = 0; c < 3; c = c + 1) begin
		over_crit[c] = (critical_limit[c] != `FTT_CRIT_DISABLE)
			&& (temp_q[c] > to_q(critical_limit[c]) + 10'd3);
		alert_hit[c] = (critical_limit[c] != `FTT_CRIT_DISABLE)
			&& (temp_q[c] > to_q(critical_limit[c]));
		below_crit_rel[c] = temp_q[c]
			< to_q(sat_sub(critical_limit[c], hyst[c]));
		above_start[c] = temp_q[c]
			> to_q(fan_start_temperature[c]) + 10'd3;
		below_start_rel[c] = temp_q[c]
			< to_q(sat_sub(fan_start_temperature[c], hyst[c]));
		if (!fan_active[c]) begin
			next_duty[c] = 8'h00;
		end else if (temp_q[c] > to_q(fan_start_temperature[c])) begin
			next_duty[c] = ramp_duty(minimum_fan_duty[c],
				temp_q[c] - to_q(fan_start_temperature[c]),
				fan_ramp_span[c]);
		end else begin
			next_duty[c] = minimum_fan_duty[c];
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		crit_hold <= 3'b000;
		fan_active <= 3'b000;
		fan_duty_0 <= 8'h00;
		fan_duty_1 <= 8'h00;
		fan_duty_2 <= 8'h00;
		overtemp_signal_pin_oe <= 1'b0;
	end else begin
		for (fc = 0; fc < 3; fc = fc + 1) begin
			if (over_crit[fc]) begin
				crit_hold[fc] <= 1'b1;
			end else if (below_crit_rel[fc]
				|| critical_limit[fc] == `FTT_CRIT_DISABLE) begin
				crit_hold[fc] <= 1'b0;
			end
			if (above_start[fc]) begin
				fan_active[fc] <= 1'b1;
			end else if (below_start_rel[fc]) begin
				fan_active[fc] <= 1'b0;
			end
		end
		// Every output goes to full while any channel is held, so a hung
		// host still gets cooling.
		if (|crit_hold || |over_crit) begin
			fan_duty_0 <= `FTT_DUTY_FULL;
			fan_duty_1 <= `FTT_DUTY_FULL;
			fan_duty_2 <= `FTT_DUTY_FULL;
		end else begin
			fan_duty_0 <= next_duty[0];
			fan_duty_1 <= next_duty[1];
			fan_duty_2 <= next_duty[2];
		end
		overtemp_signal_pin_oe <= pin_out_en && |alert_hit;
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path. Address and data are held separately and the
// register is written once both are in; one response at a time.

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;

wire [7:0] w_idx = aw_addr[ADDR_W-1:2];
wire do_write = aw_held && w_held && !s_axi_bvalid;
wire wr_ok = do_write && is_mapped(w_idx) && w_strb[0] && !lock;
wire [7:0] wb = w_data[7:0];

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= {ADDR_W{1'b0}};
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `FTT_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(w_idx) ?
				`FTT_RESP_OKAY : `FTT_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		for (rc = 0; rc < 3; rc = rc + 1) begin
			fan_start_temperature[rc] <= `FTT_RST_START;
			critical_limit[rc] <= `FTT_RST_CRIT;
			minimum_fan_duty[rc] <= `FTT_RST_MIN_DUTY;
			fan_ramp_span[rc] <= `FTT_RST_RAMP;
		end
		remote1_hyst_nibble <= RST_HYST_R1_LOC[7:4];
		local_hyst_nibble <= RST_HYST_R1_LOC[3:0];
		remote2_hyst_nibble <= `FTT_RST_HYST_R2;
		test_on <= 1'b0;
		remote1_temp_offset <= `FTT_RST_ZERO;
		lock <= 1'b0;
		offset_coarse <= 1'b0;
		pin_out_en <= 1'b0;
	end else if (wr_ok) begin
		case (w_idx)
		`FTT_IDX_GROUP_CTRL: begin
			// Lock only sets; reset is the only way back out.
			lock <= wb[`FTT_CTRL_LOCK_BIT];
			offset_coarse <= wb[`FTT_CTRL_OFS_RANGE_BIT];
			pin_out_en <= wb[`FTT_CTRL_PIN_OUT_BIT];
		end
		`FTT_IDX_RAMP_R1: fan_ramp_span[0] <= wb[2:0];
		`FTT_IDX_RAMP_LOC: fan_ramp_span[1] <= wb[2:0];
		`FTT_IDX_RAMP_R2: fan_ramp_span[2] <= wb[2:0];
		`FTT_IDX_MIN_DUTY_R1: minimum_fan_duty[0] <= wb;
		`FTT_IDX_MIN_DUTY_LOC: minimum_fan_duty[1] <= wb;
		`FTT_IDX_MIN_DUTY_R2: minimum_fan_duty[2] <= wb;
		`FTT_IDX_START_R1: fan_start_temperature[0] <= wb;
		`FTT_IDX_START_LOC: fan_start_temperature[1] <= wb;
		`FTT_IDX_START_R2: fan_start_temperature[2] <= wb;
		`FTT_IDX_CRIT_R1: critical_limit[0] <= wb;
		`FTT_IDX_CRIT_LOC: critical_limit[1] <= wb;
		`FTT_IDX_CRIT_R2: critical_limit[2] <= wb;
		`FTT_IDX_HYST_R1_LOC: begin
			local_hyst_nibble <= wb[3:0];
			remote1_hyst_nibble <= wb[7:4];
		end
		`FTT_IDX_HYST_R2: remote2_hyst_nibble <= wb[7:4];
		// Only bit 0 is kept; the upper bits are not storage.
		`FTT_IDX_PIN_TEST: test_on <= wb[`FTT_PIN_TEST_ON_BIT];
		`FTT_IDX_R1_OFFSET: remote1_temp_offset <= wb;
		default: begin
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path: one cycle from address to data.

assign s_axi_arready = !s_axi_rvalid;

wire [7:0] r_idx = s_axi_araddr[ADDR_W-1:2];
reg [7:0] rd_byte;

always @* begin
	case (r_idx)
	`FTT_IDX_GROUP_CTRL: rd_byte = {5'h00, pin_out_en, offset_coarse, lock};
	`FTT_IDX_RAMP_R1: rd_byte = {5'h00, fan_ramp_span[0]};
	`FTT_IDX_RAMP_LOC: rd_byte = {5'h00, fan_ramp_span[1]};
	`FTT_IDX_RAMP_R2: rd_byte = {5'h00, fan_ramp_span[2]};
	`FTT_IDX_STATUS: rd_byte = {1'b0, overtemp_signal_pin_oe, fan_active,
		crit_hold};
	`FTT_IDX_R1_CORR: rd_byte = remote1_temp[9:2];
	`FTT_IDX_MIN_DUTY_R1: rd_byte = minimum_fan_duty[0];
	`FTT_IDX_MIN_DUTY_LOC: rd_byte = minimum_fan_duty[1];
	`FTT_IDX_MIN_DUTY_R2: rd_byte = minimum_fan_duty[2];
	`FTT_IDX_START_R1: rd_byte = fan_start_temperature[0];
	`FTT_IDX_START_LOC: rd_byte = fan_start_temperature[1];
	`FTT_IDX_START_R2: rd_byte = fan_start_temperature[2];
	`FTT_IDX_CRIT_R1: rd_byte = critical_limit[0];
	`FTT_IDX_CRIT_LOC: rd_byte = critical_limit[1];
	`FTT_IDX_CRIT_R2: rd_byte = critical_limit[2];
	`FTT_IDX_HYST_R1_LOC: rd_byte = {remote1_hyst_nibble, local_hyst_nibble};
	`FTT_IDX_HYST_R2: rd_byte = {remote2_hyst_nibble, 4'h0};
	`FTT_IDX_PIN_TEST: rd_byte = {7'h00, test_on};
	`FTT_IDX_R1_OFFSET: rd_byte = remote1_temp_offset;
	default: rd_byte = 8'h00;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `FTT_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= {24'h000000, rd_byte};
		s_axi_rresp <= is_mapped(r_idx) ? `FTT_RESP_OKAY : `FTT_RESP_SLVERR;
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule

// *** ftt_bank_bench.sv ***
// Self-checking bench for the fan threshold bank.
module ftt_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [9:0] aw = 0, ar = 0, t0 = 0, t1 = 0, t2 = 0;
	logic [31:0] wd = 0, got;
	logic [1:0] rsp;
	logic [7:0] mdl [8'h67:8'h70];
	wire awr, wrr, bv, arr, rv, tst, po, poe, alert, spin;
	wire [1:0] br, rr;
	wire [31:0] rd;
	wire [7:0] d0, d1, d2;
	integer n_fail = 0, n_compared = 0, seed = 32'h069b, i, v;
	always #25 aclk = ~aclk;
	ftt_bank ftt_bank_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .remote1_temp_raw(t0), .local_temp(t1),
		.remote2_temp(t2), .fan_duty_0(d0), .fan_duty_1(d1),
		.fan_duty_2(d2), .pin_chain_test_on(tst),
		.overtemp_signal_pin_o(po), .overtemp_signal_pin_oe(poe));
	ftt_fan_side ftt_fan_side_i (.duty_0(d0), .pin_o(po), .pin_oe(poe),
		.alert_line(alert), .fan0_spins(spin));
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Ready is raised late at random so the answer must stand meanwhile.
	task automatic wr(input [7:0] ix, input [7:0] d);
		@(posedge aclk);
		aw <= {ix, 2'b00};
		wd <= {24'h000000, d};
		awv <= 1;
		wv <= 1;
		fork
			begin do @(posedge aclk); while (!awr); awv <= 0; end
			begin do @(posedge aclk); while (!wrr); wv <= 0; end
		join
		repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
		bry <= 1;
		do @(posedge aclk); while (!bv);
		bry <= 0;
		rsp = br;
	endtask
	task automatic rdr(input [7:0] ix);
		@(posedge aclk);
		ar <= {ix, 2'b00};
		arv <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
		rry <= 1;
		do @(posedge aclk); while (!rv);
		rry <= 0;
		got = rd;
		rsp = rr;
	endtask
	function automatic [7:0] ramp(input integer t);
		integer x;
		x = 128 + ((127 * (t - 4 * 8'h5A)) >>> 5);
		return x > 255 ? 8'hFF : x[7:0];
	endfunction
	task automatic heat(input integer t, input [7:0] e0, e1, e2);
		@(posedge aclk);
		t1 <= t[9:0];
		repeat (3) @(posedge aclk);
		chk("fan_duty_0", d0, e0);
		chk("fan_duty_1", d1, e1);
		chk("fan_duty_2", d2, e2);
		chk("fan0 spins", spin, e0 != 8'h00);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		give_verdict;
	end
	initial begin
		for (i = 8'h67; i <= 8'h70; i++)
			mdl[i] = i < 8'h6A ? 8'h5A : i < 8'h6D ? 8'h64 : 8'h00;
		mdl[8'h6D] = 8'h44;
		mdl[8'h6E] = 8'h40;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		for (i = 8'h67; i <= 8'h70; i++) begin
			rdr(i[7:0]);
			chk("reset value", got, {24'h000000, mdl[i]});
		end
		rdr(8'h7F);
		chk("unmapped resp", rsp, 2'b10);
		$display("reset values done");
		// Hysteresis nibbles stay at four or more to keep the fan quiet.
		for (i = 8'h67; i <= 8'h6E; i++) begin
			v = $random(seed);
			if (i >= 8'h6D) v = v | 8'h44;
			wr(i[7:0], v[7:0]);
			rdr(i[7:0]);
			chk("readback", got, i == 8'h6E ? v[7:4] << 4 : v[7:0]);
		end
		@(posedge aclk);
		aresetn <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		$display("register round trip done");
		heat(4 * 8'h5B, 0, ramp(4 * 8'h5B), 0);
		heat(4 * 8'h58, 0, 8'h80, 0);
		heat(4 * 8'h55, 0, 0, 0);
		heat(4 * 8'h65, 8'hFF, 8'hFF, 8'hFF);
		heat(4 * 8'h61, 8'hFF, 8'hFF, 8'hFF);
		heat(4 * 8'h5F, 0, ramp(4 * 8'h5F), 0);
		wr(8'h01, 8'h04);
		heat(4 * 8'h64 + 1, 0, 8'hFF, 0);
		chk("alert line", alert, 1'b0);
		heat(4 * 8'h64, 0, 8'hFF, 0);
		chk("alert line", alert, 1'b1);
		// Ramp code 0 spans two degrees: the slope is four times steeper.
		wr(8'h03, 8'h00);
		heat(4 * 8'h5B, 0, 128 + 127 * 4 / 8, 0);
		wr(8'h6B, 8'h80);
		heat(10'h3FF, 0, 8'hFF, 0);
		wr(8'h6B, 8'h02);
		wr(8'h6D, 8'h4F);
		heat(12, 8'hFF, 8'hFF, 8'hFF);
		heat(0, 8'hFF, 8'hFF, 8'hFF);
		$display("fan loop done");
		wr(8'h6F, 8'h01);
		chk("test mode", tst, 1'b1);
		wr(8'h6F, 8'h00);
		chk("test mode", tst, 1'b0);
		wr(8'h70, 8'h04);
		t0 <= 10'd200;
		rdr(8'h06);
		chk("remote1 fine", got, 50 + 4 * 2 / 4);
		wr(8'h01, 8'h02);
		rdr(8'h06);
		chk("remote1 coarse", got, 50 + 4);
		$display("test mode and offset done");
		wr(8'h01, 8'h01);
		wr(8'h67, 8'h11);
		chk("locked resp", rsp, 2'b00);
		rdr(8'h67);
		chk("locked value", got, 8'h5A);
		$display("lock done");
		give_verdict;
	end
endmodule

// *** ftt_bank_chk.sv ***
// Bus handshake and pin checks for the fan threshold bank.
module ftt_bank_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pin_chain_test_on,
	input wire overtemp_signal_pin_o,
	input wire overtemp_signal_pin_oe,
	input wire [7:0] fan_duty_0,
	input wire [7:0] fan_duty_1
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer mistimed");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_rhi: assert property (p_rhi) else $error("read upper bits set");
	property p_test; $changed(pin_chain_test_on) |-> $rose(s_axi_bvalid);
	endproperty
	a_test: assert property (p_test) else $error("test mode moved alone");
	property p_od; overtemp_signal_pin_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("alert pin driven high");
	c_wr: cover property (s_axi_bvalid && !s_axi_bready);
	c_rd: cover property (s_axi_rvalid && !s_axi_rready);
	c_oe: cover property (overtemp_signal_pin_oe);
	c_full: cover property (fan_duty_0 == 8'hFF && fan_duty_1 == 8'hFF);
endmodule

bind ftt_bank ftt_bank_chk ftt_bank_chk_i (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .pin_chain_test_on, .overtemp_signal_pin_o,
	.overtemp_signal_pin_oe, .fan_duty_0, .fan_duty_1);

// *** ftt_bank_regs.vh ***
// Register indices, field positions and reset values of the fan threshold bank.
`ifndef FTT_BANK_REGS_VH
`define FTT_BANK_REGS_VH

// Byte address is four times the register index.
`define FTT_IDX_GROUP_CTRL 8'h01
`define FTT_IDX_RAMP_R1 8'h02
`define FTT_IDX_RAMP_LOC 8'h03
`define FTT_IDX_RAMP_R2 8'h04
`define FTT_IDX_STATUS 8'h05
`define FTT_IDX_R1_CORR 8'h06
`define FTT_IDX_MIN_DUTY_R1 8'h64
`define FTT_IDX_MIN_DUTY_LOC 8'h65
`define FTT_IDX_MIN_DUTY_R2 8'h66
`define FTT_IDX_START_R1 8'h67
`define FTT_IDX_START_LOC 8'h68
`define FTT_IDX_START_R2 8'h69
`define FTT_IDX_CRIT_R1 8'h6A
`define FTT_IDX_CRIT_LOC 8'h6B
`define FTT_IDX_CRIT_R2 8'h6C
`define FTT_IDX_HYST_R1_LOC 8'h6D
`define FTT_IDX_HYST_R2 8'h6E
`define FTT_IDX_PIN_TEST 8'h6F
`define FTT_IDX_R1_OFFSET 8'h70

// Group control fields.
`define FTT_CTRL_LOCK_BIT 0
`define FTT_CTRL_OFS_RANGE_BIT 1
`define FTT_CTRL_PIN_OUT_BIT 2

`define FTT_PIN_TEST_ON_BIT 0

// Reset values.
`define FTT_RST_START 8'h5A
`define FTT_RST_CRIT 8'h64
`define FTT_RST_HYST_R1_LOC 8'h44
`define FTT_RST_HYST_R2 4'h4
`define FTT_RST_MIN_DUTY 8'h80
`define FTT_RST_RAMP 3'h2
`define FTT_RST_ZERO 8'h00

// Limit value that switches the forced full-duty path off.
`define FTT_CRIT_DISABLE 8'h80
`define FTT_DUTY_FULL 8'hFF

`define FTT_RESP_OKAY 2'b00
`define FTT_RESP_SLVERR 2'b10

`endif

// *** ftt_fan_side.sv ***
// Far-side model: a fan and the pulled-up alert line.
module ftt_fan_side (
	input wire [7:0] duty_0,
	input wire pin_o,
	input wire pin_oe,
	output wire alert_line,
	output wire fan0_spins
);
	timeunit 1ns;
	timeprecision 1ns;
	// The line has a pull-up, so a released pin reads high.
	assign alert_line = pin_oe ? pin_o : 1'b1;
	assign fan0_spins = duty_0 != 8'h00;
endmodule
